// ---- rtl/sbtc_timer.sv ----
// Purpose: Sixteen bit timer/counter with APB registers and interrupt
// Assumes: pclk is the oscillator clock; external input is asynchronous
// Notes: Count registers read back the live count, except a wide-mode high read, which returns the latch
// How it works
// R1 - Sixteen-bit count held as two bytes
// R2 - Rollover from maximum to zero sets flag
// R3 - Special event trigger clears the count
// R4 - Counts only while run bit set
// R5 - Reset disables timer, control reads zero
// R6 - Wide bit selects 16-bit or byte access
// R7 - Prescale codes 00/01 divide by one/two
// R8 - Oscillator enable drives oscillator on/off
// R9 - External clock synchronised unless bypass set
// R10 - Source bit picks pin edges or core/4
// R11 - Low and high byte holding registers
// R12 - Both count bytes readable and writable anytime
// R13 - Prescale codes 10/11 divide four/eight
// R14 - Wide mode latches high on low read, buffers writes
// R15 - Prescaler pulse advances count; writes clear it
`timescale 1ns/1ps
`default_nettype none
module sbtc_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_input,
    input wire logic special_event_trigger,
    output logic own_oscillator_enable,
    output logic irq
);
    // Status width taken once from the package, ahead of its first use
    localparam int SBTC_ST_W = sbtc_pkg::SBTC_ST_W;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] ctrl_r, ctrl_nxt; // Timer control register
    logic [15:0] count_r, count_nxt; // Live count
    logic [2:0] pre_r, pre_nxt; // Prescaler counter
    logic [1:0] int_div_r, int_div_nxt; // Core clock divide by four
    logic [7:0] rd_hi_buf_r, rd_hi_buf_nxt; // High byte read latch
    logic [7:0] wr_hi_buf_r, wr_hi_buf_nxt; // High byte write buffer
    logic [SBTC_ST_W-1:0] status_r, status_nxt; // Sticky events
    logic [SBTC_ST_W-1:0] mask_r, mask_nxt; // Interrupt mask
    logic ext_s1_r, ext_s2_r, ext_prev_r; // Two-flop sync, edge delay
    // Two extra resample stages, used only while synchronisation is on
    logic ext_raw1_r, ext_raw2_r;
    logic [31:0] prdata_r, prdata_nxt; // Registered read data
    // Decode helpers
    logic wr_en, rd_setup, hit;
    logic tick, src_edge, pre_pulse, wr_count;
    logic [2:0] pre_last;
    logic [SBTC_ST_W-1:0] events;

    // ****************************************************************
    // APB decode: zero wait states, error on unmapped address
    // ****************************************************************
    assign wr_en = psel && penable && pwrite;
    // Reads are decoded in the setup phase so data stands in access
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    always_comb begin
        hit = (paddr == sbtc_pkg::SBTC_OFS_CONTROL) ||
              (paddr == sbtc_pkg::SBTC_OFS_LOW) ||
              (paddr == sbtc_pkg::SBTC_OFS_HIGH) ||
              (paddr == sbtc_pkg::SBTC_OFS_STATUS) ||
              (paddr == sbtc_pkg::SBTC_OFS_MASK);
    end
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_r;

    // ****************************************************************
    // Clock source and prescaler
    // ****************************************************************
    // Synchronised edge: first stage feeds only the second
    // Each path compares a stage with its own successor, so one pin
    // edge gives exactly one single-cycle pulse
    assign src_edge = ctrl_r[sbtc_pkg::SBTC_BIT_SYNCN]
        ? (ext_s2_r && !ext_prev_r) // see R9 bypass, two stages less
        : (ext_raw1_r && !ext_raw2_r); // see R9
    always_comb begin
        // Core clock / 4 or rising pin edge; see R10
        if (ctrl_r[sbtc_pkg::SBTC_BIT_SRC]) begin
            tick = src_edge;
        end else begin
            tick = (int_div_r == sbtc_pkg::SBTC_INT_DIV);
        end
    end
    always_comb begin
        // Prescale last count: 0,1,3,7; see R7 R13
        unique case (ctrl_r[sbtc_pkg::SBTC_BIT_PS_HI:
                            sbtc_pkg::SBTC_BIT_PS_LO])
            2'h0: pre_last = 3'h0;
            2'h1: pre_last = 3'h1;
            2'h2: pre_last = 3'h3;
            2'h3: pre_last = 3'h7;
        endcase
    end
    // At-or-above compare: a smaller divide chosen mid-count must not
    // leave the prescaler climbing past its new last value
    assign pre_pulse = ctrl_r[sbtc_pkg::SBTC_BIT_RUN] && tick &&
                       (pre_r >= pre_last); // see R4 R15
    assign wr_count = wr_en && ((paddr == sbtc_pkg::SBTC_OFS_LOW) ||
        (paddr == sbtc_pkg::SBTC_OFS_HIGH &&
         !ctrl_r[sbtc_pkg::SBTC_BIT_WIDE]));
    assign own_oscillator_enable = ctrl_r[sbtc_pkg::SBTC_BIT_OSC]; // see R8

    // ****************************************************************
    // Next state of counter, registers and events
    // ****************************************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        count_nxt = count_r;
        pre_nxt = pre_r;
        int_div_nxt = int_div_r + 2'h1; // Free running core/4
        rd_hi_buf_nxt = rd_hi_buf_r;
        wr_hi_buf_nxt = wr_hi_buf_r;
        mask_nxt = mask_r;
        events = '0;
        prdata_nxt = 32'h0000_0000;
        // Prescaler runs on ticks while enabled
        if (ctrl_r[sbtc_pkg::SBTC_BIT_RUN] && tick) begin
            pre_nxt = (pre_r >= pre_last) ? 3'h0 : pre_r + 3'h1;
        end
        // Count advance and rollover
        if (pre_pulse) begin
            count_nxt = count_r + 16'h0001; // see R15
            if (count_r == sbtc_pkg::SBTC_COUNT_MAX) begin
                events[sbtc_pkg::SBTC_ST_OVF] = 1'b1; // see R2
            end
        end
        // Trigger wins over counting
        if (special_event_trigger) begin
            count_nxt = sbtc_pkg::SBTC_COUNT_RESET; // see R3
            events[sbtc_pkg::SBTC_ST_TRIG] = 1'b1;
        end
        // Software writes win over both; see R12
        if (wr_en) begin
            unique case (paddr)
                sbtc_pkg::SBTC_OFS_CONTROL: begin
                    ctrl_nxt = pwdata[7:0] & sbtc_pkg::SBTC_CTRL_MASK;
                end
                sbtc_pkg::SBTC_OFS_LOW: begin
                    count_nxt[7:0] = pwdata[7:0]; // see R11
                    if (ctrl_r[sbtc_pkg::SBTC_BIT_WIDE]) begin
                        count_nxt[15:8] = wr_hi_buf_r; // see R14
                    end
                end
                sbtc_pkg::SBTC_OFS_HIGH: begin
                    if (ctrl_r[sbtc_pkg::SBTC_BIT_WIDE]) begin
                        wr_hi_buf_nxt = pwdata[7:0]; // see R6 R14
                    end else begin
                        count_nxt[15:8] = pwdata[7:0]; // see R6
                    end
                end
                sbtc_pkg::SBTC_OFS_MASK: begin
                    mask_nxt = pwdata[SBTC_ST_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (wr_count) begin
            pre_nxt = 3'h0; // see R15
        end
        // Reads: data is captured at the setup edge, so it stands
        // through the access phase, where the master takes it
        if (rd_setup) begin
            unique case (paddr)
                sbtc_pkg::SBTC_OFS_CONTROL: begin
                    prdata_nxt = {24'h000000, ctrl_r}; // see R5
                end
                sbtc_pkg::SBTC_OFS_LOW: begin
                    prdata_nxt = {24'h000000, count_r[7:0]};
                    // Same edge as the low byte keeps the pair coherent
                    rd_hi_buf_nxt = count_r[15:8]; // see R14
                end
                sbtc_pkg::SBTC_OFS_HIGH: begin
                    prdata_nxt = {24'h000000,
                        ctrl_r[sbtc_pkg::SBTC_BIT_WIDE] ? rd_hi_buf_r
                                              : count_r[15:8]}; // see R6
                end
                sbtc_pkg::SBTC_OFS_STATUS: begin
                    prdata_nxt = {30'h00000000, status_r};
                end
                sbtc_pkg::SBTC_OFS_MASK: begin
                    prdata_nxt = {30'h00000000, mask_r};
                end
                default: begin
                end
            endcase
        end
        // Sticky status: write one clears, new event wins
        status_nxt = status_r;
        if (wr_en && paddr == sbtc_pkg::SBTC_OFS_STATUS) begin
            status_nxt = status_r & ~pwdata[SBTC_ST_W-1:0];
        end
        status_nxt = status_nxt | events;
    end

    // ****************************************************************
    // Registers; reset disables the timer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= sbtc_pkg::SBTC_CTRL_RESET; // see R5
            count_r <= sbtc_pkg::SBTC_COUNT_RESET; // see R1
            pre_r <= 3'h0;
            int_div_r <= 2'h0;
            rd_hi_buf_r <= 8'h00;
            wr_hi_buf_r <= 8'h00;
            status_r <= '0;
            mask_r <= '0;
            prdata_r <= 32'h0000_0000;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_prev_r <= 1'b0;
            ext_raw1_r <= 1'b0;
            ext_raw2_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            count_r <= count_nxt;
            pre_r <= pre_nxt;
            int_div_r <= int_div_nxt;
            rd_hi_buf_r <= rd_hi_buf_nxt;
            wr_hi_buf_r <= wr_hi_buf_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
            ext_s1_r <= external_count_input;
            ext_s2_r <= ext_s1_r;
            ext_prev_r <= ext_s2_r;
            // Sync mode resamples twice more, standing in for the
            // alignment to the core tick; bypass skips these two stages
            ext_raw1_r <= ext_prev_r;
            ext_raw2_r <= ext_raw1_r;
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(status_r & mask_r);

    // ****************************************************************
    // Checks
    // ****************************************************************
    // All checks live in the pclk domain and rest while in reset
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    overflow_sets_a: assert property ( // see R2
        pre_pulse && count_r == 16'hffff && !special_event_trigger
        && !wr_count |=> count_r == 16'h0000 && status_r[0])
        else $error("overflow did not wrap and flag");
    trigger_clears_a: assert property ( // see R3
        special_event_trigger && !wr_count |=> count_r == 16'h0000)
        else $error("trigger did not clear count");
    stop_holds_a: assert property ( // see R4
        !ctrl_r[0] && !special_event_trigger && !wr_en
        |=> $stable(count_r))
        else $error("count moved while stopped");
    bit6_zero_a: assert property ( // see R5
        !ctrl_r[6])
        else $error("unimplemented control bit set");
    wide_latch_a: assert property ( // see R14
        rd_setup && paddr == sbtc_pkg::SBTC_OFS_LOW
        |=> rd_hi_buf_r == $past(count_r[15:8]))
        else $error("high byte not latched on low read");
    div_one_a: assert property ( // see R7
        ctrl_r[5:4] == 2'h0 && ctrl_r[0] && tick |-> pre_pulse)
        else $error("divide by one missed a tick");
    div_eight_a: assert property ( // see R13
        pre_pulse && ctrl_r[5:4] == 2'h3 |-> pre_r == 3'h7)
        else $error("divide by eight pulse early");
    osc_follow_a: assert property ( // see R8
        own_oscillator_enable == ctrl_r[3])
        else $error("oscillator enable mismatch");
    internal_rate_a: assert property ( // see R10
        !ctrl_r[1] && tick |=> !tick [*3])
        else $error("internal tick faster than core/4");
    write_clear_a: assert property ( // see R15
        wr_count |=> pre_r == 3'h0)
        else $error("prescaler not cleared on write");
    // One pin edge must give one tick, never a run of them
    src_once_a: assert property ( // see R9
        src_edge |=> $changed(ctrl_r[sbtc_pkg::SBTC_BIT_SYNCN])
        || !src_edge)
        else $error("pin edge counted more than once");
    // A wide low write carries the buffered high byte with it
    sequence wide_low_write_s;
        wr_en && paddr == sbtc_pkg::SBTC_OFS_LOW
        && ctrl_r[sbtc_pkg::SBTC_BIT_WIDE];
    endsequence
    wide_load_a: assert property ( // see R14
        wide_low_write_s |=> count_r[15:8] == $past(wr_hi_buf_r))
        else $error("wide low write lost the buffered high byte");
endmodule
`default_nettype wire

// ---- rtl/sbtc_pkg.sv ----
// Purpose: Shared constants for the sixteen bit timer/counter block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses on the APB bus
package sbtc_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] SBTC_OFS_CONTROL = 8'h00; // Timer control
    localparam logic [7:0] SBTC_OFS_LOW = 8'h04; // Count low byte
    localparam logic [7:0] SBTC_OFS_HIGH = 8'h08; // Count high byte
    localparam logic [7:0] SBTC_OFS_STATUS = 8'h0c; // Sticky events
    localparam logic [7:0] SBTC_OFS_MASK = 8'h10; // Interrupt mask
    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int SBTC_BIT_RUN = 0; // Timer run
    localparam int SBTC_BIT_SRC = 1; // Clock source select
    localparam int SBTC_BIT_SYNCN = 2; // External sync bypass
    localparam int SBTC_BIT_OSC = 3; // Own oscillator enable
    localparam int SBTC_BIT_PS_LO = 4; // Prescale select low bit
    localparam int SBTC_BIT_PS_HI = 5; // Prescale select high bit
    localparam int SBTC_BIT_WIDE = 7; // Wide access enable
    localparam logic [7:0] SBTC_CTRL_MASK = 8'hbf; // Bit 6 unimplemented
    localparam logic [7:0] SBTC_CTRL_RESET = 8'h00; // Value after reset
    // ****************************************************************
    // Status bits and counts
    // ****************************************************************
    localparam int SBTC_ST_OVF = 0; // Overflow event
    localparam int SBTC_ST_TRIG = 1; // Special event trigger seen
    localparam int SBTC_ST_W = 2; // Status width
    localparam logic [15:0] SBTC_COUNT_RESET = 16'h0000; // Count at reset
    localparam logic [15:0] SBTC_COUNT_MAX = 16'hffff; // Rollover point
    localparam logic [1:0] SBTC_INT_DIV = 2'h3; // Core clock / 4 minus 1
endpackage

// ---- sim/sbtc_ext_src.sv ----
// Purpose: Model of the external count source on the pin side
// Assumes: Pin idles low between bursts; edges launched on pclk
// Notes: Half period is in pclk cycles, slow enough for the synchroniser
`timescale 1ns/1ps
`default_nettype none
module sbtc_ext_src (
    input wire logic clk,
    output logic pin
);
    // *****************************************
    // Edge generator
    // *****************************************
    // Idle low so that no stray edge appears at start
    initial begin
        pin = 1'b0;
    end
    // Burst of n rising edges, then back to idle low
    task automatic pulses(input int n, input int half);
        for (int k = 0; k < n; k++) begin
            repeat (half) @(posedge clk);
            pin <= 1'b1;
            repeat (half) @(posedge clk);
            pin <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the timer/counter over APB
// Assumes: Read data stands in the access phase, taken at its last edge
// Notes: Run lengths are timed loosely, so counts allow one tick of slack
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] CTL = sbtc_pkg::SBTC_OFS_CONTROL;
    localparam logic [7:0] LO = sbtc_pkg::SBTC_OFS_LOW;
    localparam logic [7:0] HI = sbtc_pkg::SBTC_OFS_HIGH;
    localparam logic [7:0] ST = sbtc_pkg::SBTC_OFS_STATUS;
    localparam logic [7:0] MSK = sbtc_pkg::SBTC_OFS_MASK;
    logic pclk = 1'b0; // Core clock
    logic presetn = 1'b0; // Reset, low for the first cycles
    logic psel = 1'b0; // Bus select
    logic penable = 1'b0; // Access phase
    logic pwrite = 1'b0; // Direction
    logic trig = 1'b0; // Special event trigger from the compare unit
    logic [7:0] paddr = 8'h00; // Byte address
    logic [31:0] pwdata = 32'h00000000; // Write data
    logic [31:0] prdata, r; // Read data and its captured copy
    logic pready, pslverr, ext_pin, osc_en, irq, e;
    logic [15:0] v, v2; // Count snapshots
    int fails = 0, comparisons = 0, cyc = 0, i;
    // *****************************************
    // Clock, design and far side
    // *****************************************
    always #4 pclk = ~pclk;
    sbtc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_input(ext_pin),
        .special_event_trigger(trig), .own_oscillator_enable(osc_en),
        .irq(irq));
    sbtc_ext_src src_u (.clk(pclk), .pin(ext_pin));
    // *****************************************
    // Bus tasks and compares
    // *****************************************
    // One APB transfer; read data and error flag are taken at the edge
    // where pready is seen high, and only then is the request released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        e = pslverr;
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Byte-wise count access, used with the wide bit clear
    task automatic cnt(output logic [15:0] c);
        apb(1'b0, LO, 32'h00000000);
        c[7:0] = r[7:0];
        apb(1'b0, HI, 32'h00000000);
        c[15:8] = r[7:0];
    endtask
    task automatic setcnt(input logic [15:0] c);
        apb(1'b1, HI, {24'h000000, c[15:8]});
        apb(1'b1, LO, {24'h000000, c[7:0]});
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Count after a timed run; one tick either way is phase slack
    task automatic near(input logic [15:0] got, input int exp);
        comparisons++;
        if ($isunknown(got) || got > exp + 1 || got + 1 < exp) begin
            fails++;
            $display("wrong value at %0t: count %h near %0d", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test;
        end
    end
    // *****************************************
    // Test sequence
    // *****************************************
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTL, 32'h00000000);
        chk(r, 32'h00000000);
        chk({31'h0, osc_en}, 32'h00000000);
        apb(1'b1, CTL, 32'h000000ff);
        apb(1'b0, CTL, 32'h00000000);
        chk(r, 32'h000000bf);
        chk({31'h0, osc_en}, 32'h00000001);
        // Unmapped address is refused and reads zero
        apb(1'b0, 8'h14, 32'h00000000);
        chk({31'h0, e}, 32'h00000001);
        chk(r, 32'h00000000);
        // Internal clock through every prescale code, bit 2 ignored
        for (i = 0; i < 4; i++) begin
            apb(1'b1, CTL, 32'h00000000);
            setcnt(16'h0000);
            apb(1'b1, CTL, {26'h0, i[1:0], 4'h5});
            repeat ((40 << i) - 3) @(posedge pclk);
            apb(1'b1, CTL, 32'h00000000);
            cnt(v);
            near(v, 10);
        end
        // Stopped timer holds its value
        repeat (50) @(posedge pclk);
        cnt(v2);
        chk({16'h0, v2}, {16'h0, v});
        // Rollover sets the sticky flag, mask drives the interrupt
        setcnt(16'hfffe);
        apb(1'b1, CTL, 32'h00000001);
        repeat (20) @(posedge pclk);
        apb(1'b1, CTL, 32'h00000000);
        apb(1'b0, ST, 32'h00000000);
        chk(r, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
        apb(1'b1, MSK, 32'h00000003);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, 32'h00000001);
        apb(1'b1, ST, 32'h00000001);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, 32'h00000000);
        // Trigger clears the count even while stopped
        setcnt(16'h1234);
        @(posedge pclk);
        trig <= 1'b1;
        @(posedge pclk);
        trig <= 1'b0;
        cnt(v);
        chk({16'h0, v}, 32'h00000000);
        chk({31'h0, irq}, 32'h00000001);
        apb(1'b1, ST, 32'h00000002);
        apb(1'b0, ST, 32'h00000000);
        chk(r, 32'h00000000);
        // Pin edges, synchronised and bypassed
        for (i = 0; i < 2; i++) begin
            setcnt(16'h0000);
            apb(1'b1, CTL, {29'h0, i[0], 2'h3});
            src_u.pulses(5, 3);
            repeat (8) @(posedge pclk);
            apb(1'b1, CTL, 32'h00000000);
            cnt(v);
            chk({16'h0, v}, 32'h00000005);
        end
        // Wide mode: high write waits for low write
        setcnt(16'h0000);
        apb(1'b1, CTL, 32'h00000080);
        apb(1'b1, HI, 32'h00000056);
        apb(1'b1, CTL, 32'h00000000);
        apb(1'b0, HI, 32'h00000000);
        chk(r, 32'h00000000);
        apb(1'b1, CTL, 32'h00000080);
        apb(1'b1, LO, 32'h00000078);
        apb(1'b1, CTL, 32'h00000000);
        cnt(v);
        chk({16'h0, v}, 32'h00005678);
        // Wide mode: low read latches high for the next high read
        apb(1'b1, CTL, 32'h00000080);
        apb(1'b0, LO, 32'h00000000);
        apb(1'b1, CTL, 32'h00000000);
        apb(1'b1, HI, 32'h00000011);
        apb(1'b1, CTL, 32'h00000080);
        apb(1'b0, HI, 32'h00000000);
        chk(r, 32'h00000056);
        apb(1'b1, CTL, 32'h00000000);
        apb(1'b0, HI, 32'h00000000);
        chk(r, 32'h00000011);
        stop_test;
    end
endmodule
`default_nettype wire
